// >>> hw/acc_rotate_map.svh
// constants for the accumulator rotate and bit-set datapath
`ifndef ACC_ROTATE_MAP_SVH
`define ACC_ROTATE_MAP_SVH

// opcode bytes
`define OPC_ROTATE_LEFT_VIA_CARRY 8'h33
`define OPC_ROTATE_RIGHT 8'h03
`define OPC_ROTATE_RIGHT_VIA_CARRY 8'h13
`define OPC_FORCE_CARRY_ONE 8'hd3
`define OPC_FORCE_BIT_ONE 8'hd2

// direct bit address map
`define BIT_RAM_LIMIT 8'h80
`define PORT_ONE_BIT_BASE 5'h12
`define CARRY_BIT_ADDR 8'hd7

// reset values
`define ACC_RESET 8'h00
`define CARRY_RESET 1'b0
`define PORT_ONE_RESET 8'hff
`define BIT_RAM_RESET 8'h00

`endif

// >>> hw/acc_rotate_pkg.sv
// types for the accumulator rotate and bit-set datapath
package acc_rotate_pkg;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ROTATE_LEFT_VIA_CARRY,
        OP_ROTATE_RIGHT,
        OP_ROTATE_RIGHT_VIA_CARRY,
        OP_FORCE_CARRY_ONE,
        OP_FORCE_BIT_ONE,
        OP_UNKNOWN
    } op_kind_e;

endpackage : acc_rotate_pkg

// >>> hw/accumulator_rotate_and_bit_set.sv
// accumulator rotate and bit-set datapath slice of the core
//
// How it works
// - rotate left via carry: bits 0-6 move up, old carry in, bit 7 out.
// - opcode 00110011 is rotate left via carry, one byte, one cycle.
// - rotate right moves bits down, bit 0 wraps to bit 7, carry untouched.
// - rotate right via carry: bits 1-7 move down, carry in, bit 0 out.
// - opcode 00010011 is rotate right via carry, one byte, one cycle.
// - bit-set forces carry, a ram bit or a port one bit to one, no other flag.
// - setting a port latch bit changes that port pin at once, others kept.
`timescale 1ns/1ps
`include "acc_rotate_map.svh"

module accumulator_rotate_and_bit_set
    import acc_rotate_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    // instruction from the sequencer
    input wire logic execStrobe,
    input wire logic [7:0] opcode,
    input wire logic [7:0] bitAddr,
    // plain writes by other instructions
    input wire logic accWrEn,
    input wire logic [7:0] accWrData,
    input wire logic carryWrEn,
    input wire logic carryWrData,
    input wire logic portWrEn,
    input wire logic [7:0] portWrData,
    // bit readback
    input wire logic [7:0] bitRdAddr,
    output logic bitRdData,
    // state and status
    output logic [7:0] accumulator,
    output logic carryFlag,
    output logic [7:0] portOneLatch,
    output logic opDone,
    output logic opUnknown
);

    op_kind_e opKind;
    logic go;
    logic [7:0] bitRam [16];
    logic [7:0] next_accumulator;
    logic next_carry;
    logic hitPort;
    logic hitCarry;
    logic hitRam;

    assign go = ce && execStrobe;

    // full-byte compare so that look-alike opcodes never alias a rotate
    always_comb begin
        case (opcode)
            `OPC_ROTATE_LEFT_VIA_CARRY: opKind = OP_ROTATE_LEFT_VIA_CARRY;
            `OPC_ROTATE_RIGHT: opKind = OP_ROTATE_RIGHT;
            `OPC_ROTATE_RIGHT_VIA_CARRY: opKind = OP_ROTATE_RIGHT_VIA_CARRY;
            `OPC_FORCE_CARRY_ONE: opKind = OP_FORCE_CARRY_ONE;
            `OPC_FORCE_BIT_ONE: opKind = OP_FORCE_BIT_ONE;
            default: opKind = OP_UNKNOWN;
        endcase
    end

    // target decode of a direct bit address
    assign hitRam = bitAddr < `BIT_RAM_LIMIT;
    assign hitPort = bitAddr[7:3] == `PORT_ONE_BIT_BASE;
    assign hitCarry = bitAddr == `CARRY_BIT_ADDR;

    always_comb begin
        next_accumulator = accumulator;
        next_carry = carryFlag;
        case (opKind)
            OP_ROTATE_LEFT_VIA_CARRY: begin
                next_accumulator = {accumulator[6:0], carryFlag};
                next_carry = accumulator[7];
            end
            OP_ROTATE_RIGHT: begin
                next_accumulator = {accumulator[0], accumulator[7:1]};
            end
            OP_ROTATE_RIGHT_VIA_CARRY: begin
                next_accumulator = {carryFlag, accumulator[7:1]};
                next_carry = accumulator[0];
            end
            OP_FORCE_CARRY_ONE: begin
                next_carry = 1'b1;
            end
            OP_FORCE_BIT_ONE: begin
                if (hitCarry) begin
                    next_carry = 1'b1;
                end
            end
            default: begin
                next_accumulator = accumulator;
            end
        endcase
    end

    // an executing instruction wins over a plain write in the same cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            accumulator <= `ACC_RESET;
        end else if (go) begin
            accumulator <= next_accumulator;
        end else if (ce && accWrEn) begin
            accumulator <= accWrData;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            carryFlag <= `CARRY_RESET;
        end else if (go) begin
            carryFlag <= next_carry;
        end else if (ce && carryWrEn) begin
            carryFlag <= carryWrData;
        end
    end

    // the latch drives the pins directly, so a set shows on the next edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            portOneLatch <= `PORT_ONE_RESET;
        end else if (go && opKind == OP_FORCE_BIT_ONE && hitPort) begin
            portOneLatch[bitAddr[2:0]] <= 1'b1;
        end else if (ce && portWrEn) begin
            portOneLatch <= portWrData;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 16; i++) begin
                bitRam[i] <= `BIT_RAM_RESET;
            end
        end else if (go && opKind == OP_FORCE_BIT_ONE && hitRam) begin
            bitRam[bitAddr[6:3]][bitAddr[2:0]] <= 1'b1;
        end
    end

    // bit addresses outside ram, port and carry read as zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bitRdData <= 1'b0;
        end else if (ce) begin
            if (bitRdAddr < `BIT_RAM_LIMIT) begin
                bitRdData <= bitRam[bitRdAddr[6:3]][bitRdAddr[2:0]];
            end else if (bitRdAddr[7:3] == `PORT_ONE_BIT_BASE) begin
                bitRdData <= portOneLatch[bitRdAddr[2:0]];
            end else if (bitRdAddr == `CARRY_BIT_ADDR) begin
                bitRdData <= carryFlag;
            end else begin
                bitRdData <= 1'b0;
            end
        end
    end

    // every recognised instruction completes in the single machine cycle it is issued; an unknown opcode raises opUnknown instead
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            opDone <= 1'b0;
            opUnknown <= 1'b0;
        end else if (ce) begin
            opDone <= execStrobe && opKind != OP_UNKNOWN;
            opUnknown <= execStrobe && opKind == OP_UNKNOWN;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    chk_rotl_carry_result: assert property (
        go && opcode == 8'h33 |=>
            accumulator == {$past(accumulator[6:0]), $past(carryFlag)}
            && carryFlag == $past(accumulator[7]))
        else $error("rotate left via carry gave a wrong result");

    chk_rotl_one_cycle: assert property (
        go && opcode == 8'h33 |=> opDone && !opUnknown)
        else $error("rotate left via carry did not finish in one cycle");

    chk_rotr_wrap_result: assert property (
        go && opcode == 8'h03 |=>
            accumulator == {$past(accumulator[0]), $past(accumulator[7:1])}
            && $stable(carryFlag) && opDone)
        else $error("rotate right gave a wrong result or touched carry");

    chk_rotr_carry_result: assert property (
        go && opcode == 8'h13 |=>
            accumulator == {$past(carryFlag), $past(accumulator[7:1])}
            && carryFlag == $past(accumulator[0]))
        else $error("rotate right via carry gave a wrong result");

    chk_rotr_carry_cycle: assert property (
        go && opcode == 8'h13 |=> opDone ##1 (!opDone || $past(execStrobe)))
        else $error("rotate right via carry did not finish in one cycle");

    chk_set_carry_one: assert property (
        go && (opcode == 8'hd3 || (opcode == 8'hd2 && bitAddr == 8'hd7)) |=>
            carryFlag && $stable(accumulator))
        else $error("bit set of carry failed or touched the accumulator");

    chk_set_ram_bit: assert property (
        go && opcode == 8'hd2 && !bitAddr[7] |=>
            bitRam[$past(bitAddr[6:3])][$past(bitAddr[2:0])] && $stable(carryFlag))
        else $error("bit set of a ram bit failed or touched carry");

    chk_port_bit_set: assert property (
        go && opcode == 8'hd2 && bitAddr[7:3] == 5'h12 |=>
            portOneLatch == ($past(portOneLatch) | (8'h01 << $past(bitAddr[2:0]))))
        else $error("port latch bit set wrong or disturbed other bits");

    chk_rotr_full_decode: assert property (
        go && opcode[5:0] == 6'h03 && opcode[7:6] != 2'b00 && opcode[7:6] != 2'b11
            |=> opUnknown && $stable(accumulator))
        else $error("partial rotate right pattern was executed");

endmodule : accumulator_rotate_and_bit_set

// >>> verification/seq_model.sv
// sequencer model that issues instructions to the datapath
`timescale 1ns/1ps
module seq_model (
    // clock
    input wire logic core_clk,
    // instruction out
    output logic execStrobe,
    output logic [7:0] opcode,
    output logic [7:0] bitAddr
);
    initial begin
        execStrobe = 1'b0;
        opcode = 8'h00;
        bitAddr = 8'h00;
    end
    // caller sits just after an edge; back to back calls strobe every cycle
    task automatic issue(input logic [7:0] op, input logic [7:0] ba);
        execStrobe <= 1'b1;
        opcode <= op;
        bitAddr <= ba;
        @(posedge core_clk);
        #1;
    endtask : issue
    // idle lines move so a stale opcode can never look valid
    task automatic idle();
        execStrobe <= 1'b0;
        opcode <= ~opcode;
        bitAddr <= ~bitAddr;
    endtask : idle
endmodule : seq_model

// >>> verification/tb_top.sv
// self-checking bench for the rotate and bit-set datapath
`timescale 1ns/1ps
`include "acc_rotate_map.svh"
module tb_top;
    import acc_rotate_pkg::*;
    typedef struct packed {logic [7:0] a; logic c; logic [7:0] p; logic u;} exp_s;
    logic core_clk = 1'b0, rst_b = 1'b0, accWrEn = 1'b0, carryWrEn = 1'b0, portWrEn = 1'b0;
    logic ce = 1'b1;
    logic carryWrData = 1'b0, bitRdData, carryFlag, opDone, opUnknown, execStrobe;
    logic [7:0] accWrData = 8'h00, portWrData = 8'h00, bitRdAddr = 8'h00;
    logic [7:0] accumulator, portOneLatch, opcode, bitAddr, op, ba;
    logic [7:0] ops [7] = '{8'h33, 8'h03, 8'h13, 8'hd3, 8'hd2, 8'h43, 8'h83};
    exp_s expq [$];
    exp_s m, e;
    int failures = 0, num_checks = 0, k;
    always #12.5 core_clk = ~core_clk;
    seq_model i_seq (.core_clk(core_clk), .execStrobe(execStrobe), .opcode(opcode),
        .bitAddr(bitAddr));
    accumulator_rotate_and_bit_set i_dut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
        .execStrobe(execStrobe), .opcode(opcode), .bitAddr(bitAddr), .accWrEn(accWrEn),
        .accWrData(accWrData), .carryWrEn(carryWrEn), .carryWrData(carryWrData),
        .portWrEn(portWrEn), .portWrData(portWrData), .bitRdAddr(bitRdAddr),
        .bitRdData(bitRdData), .accumulator(accumulator), .carryFlag(carryFlag),
        .portOneLatch(portOneLatch), .opDone(opDone), .opUnknown(opUnknown));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // reference model of one instruction, queued before the strobe edge
    task automatic send(input logic [7:0] o, input logic [7:0] b);
        m.u = 1'b0;
        case (o)
            8'h33: begin k = m.c; m.c = m.a[7]; m.a = {m.a[6:0], k[0]}; end
            8'h03: m.a = {m.a[0], m.a[7:1]};
            8'h13: begin k = m.c; m.c = m.a[0]; m.a = {k[0], m.a[7:1]}; end
            8'hd3: m.c = 1'b1;
            8'hd2: begin
                if (b[7:3] == `PORT_ONE_BIT_BASE) m.p[b[2:0]] = 1'b1;
                if (b == `CARRY_BIT_ADDR) m.c = 1'b1;
            end
            default: m.u = 1'b1;
        endcase
        expq.push_back(m);
        i_seq.issue(o, b);
    endtask : send
    always @(posedge core_clk) begin
        #2;
        if (opDone === 1'b1 || opUnknown === 1'b1) begin
            if (expq.size() == 0) check("spurious result", 8'h01, 8'h00);
            else begin
                e = expq.pop_front();
                check("accumulator", accumulator, e.a);
                check("carry", 8'(carryFlag), 8'(e.c));
                check("port latch", portOneLatch, e.p);
                check("unknown", 8'(opUnknown), 8'(e.u));
                check("done", 8'(opDone), 8'(!e.u));
            end
        end
    end
    initial begin
        void'($urandom(32'hc47b));
        repeat (10) @(posedge core_clk);
        #1 rst_b = 1'b1;
        check("acc reset", accumulator, `ACC_RESET);
        check("latch reset", portOneLatch, `PORT_ONE_RESET);
        for (int r = 0; r < 5; r++) begin
            // preload through the plain write ports, then a back to back burst
            accWrEn = 1'b1;
            carryWrEn = 1'b1;
            portWrEn = 1'b1;
            accWrData = (r == 0) ? 8'hc5 : 8'($urandom);
            carryWrData = (r == 0) ? 1'b0 : 1'($urandom);
            portWrData = (r == 0) ? 8'h34 : 8'($urandom);
            @(posedge core_clk);
            #1 accWrEn = 1'b0;
            carryWrEn = 1'b0;
            portWrEn = 1'b0;
            m.a = accWrData;
            m.c = carryWrData;
            m.p = portWrData;
            for (int i = 0; i < 14; i++) begin
                op = (r == 0) ? ops[i % 7] : ops[$urandom_range(6, 0)];
                ba = {`PORT_ONE_BIT_BASE, 3'($urandom_range(7, 0))};
                // some direct-bit sets aim at the carry instead of a port pin
                if (r > 0 && $urandom_range(3, 0) == 0) ba = `CARRY_BIT_ADDR;
                send(op, ba);
            end
            i_seq.idle();
            @(posedge core_clk);
            #1;
        end
        send(8'hd2, 8'h05);
        i_seq.idle();
        bitRdAddr = 8'h05;
        repeat (2) @(posedge core_clk);
        #2 check("ram bit set", 8'(bitRdData), 8'h01);
        bitRdAddr = 8'h06;
        repeat (2) @(posedge core_clk);
        #2 check("ram bit kept", 8'(bitRdData), 8'h00);
        bitRdAddr = `CARRY_BIT_ADDR;
        repeat (2) @(posedge core_clk);
        #2 check("carry readback", 8'(bitRdData), 8'(m.c));
        // with ce low a strobe must be ignored and every register frozen
        ce = 1'b0;
        i_seq.issue(8'h33, 8'h00);
        i_seq.idle();
        @(posedge core_clk);
        #1 ce = 1'b1;
        check("frozen acc", accumulator, m.a);
        check("frozen carry", 8'(carryFlag), 8'(m.c));
        check("frozen done", 8'(opDone), 8'h00);
        for (int w = 0; w < 20 && expq.size() != 0; w++) @(posedge core_clk);
        if (expq.size() != 0) check("results pending", 8'(expq.size()), 8'h00);
        finish_test();
    end
endmodule : tb_top
